// ### shared/dslog_pkg.sv
// Purpose: constants and types for the diagnostic LED and event log block
// Assumes: APB slave, 32-bit data, pclk at 200 MHz
// Notes: history object registers sit in a window of one aligned word each
package dslog_pkg;
	// Clock and indicator timing
	localparam int CLK_MHZ = 200;
	localparam int FLASH_HALF_MS = 200;
	localparam int FLICK_HALF_MS = 50;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
	localparam int FLICK_HALF_CYC = FLICK_HALF_MS * 1000 * CLK_MHZ;
	localparam int SINGLE_OFF_SLOTS = 5;
	// History sizing
	localparam int MAX_RECORDS = 250;
	localparam logic [7:0] FIRST_SUB = 8'h06;
	localparam logic [15:0] HISTORY_INDEX = 16'h10f3;
	// Register byte offsets
	localparam logic [11:0] OFF_NEWEST_SUB = 12'h000;
	localparam logic [11:0] OFF_ACK_SUB = 12'h004;
	localparam logic [11:0] OFF_UNREAD = 12'h008;
	localparam logic [11:0] OFF_EMCY_EN = 12'h00c;
	localparam logic [11:0] OFF_COUNT = 12'h010;
	localparam logic [11:0] OFF_SEL = 12'h014;
	localparam logic [11:0] OFF_REC_CODE = 12'h018;
	localparam logic [11:0] OFF_REC_FLAGS = 12'h01c;
	localparam logic [11:0] OFF_REC_TS_LO = 12'h020;
	localparam logic [11:0] OFF_REC_TS_HI = 12'h024;
	localparam logic [11:0] OFF_OBJ_INDEX = 12'h028;
	// Reset values
	localparam logic EMCY_EN_RST = 1'b1;
	// Flag field layout
	localparam int FLAG_CONFIRMED_BIT = 4;
	localparam logic [15:0] SEV_INFO = 16'h0000;
	localparam logic [15:0] SEV_WARN = 16'h0001;
	localparam logic [15:0] SEV_ERR = 16'h0002;
	// Text index class digit
	localparam logic [3:0] CLASS_SYSINFO = 4'h0;
	localparam logic [3:0] CLASS_INFO = 4'h1;
	localparam logic [3:0] CLASS_WARN = 4'h4;
	localparam logic [3:0] CLASS_ERR = 4'h8;
	// Slave state encoding
	typedef enum logic [4:0] {
		DSLOG_INIT = 5'h01,
		DSLOG_PREOP = 5'h02,
		DSLOG_SAFEOP = 5'h04,
		DSLOG_OP = 5'h08,
		DSLOG_BOOT = 5'h10
	} dslog_state_e;
	// One diagnostic record
	typedef struct packed {
		logic [31:0] code;
		logic [15:0] flags;
		logic [15:0] text_index;
		logic [63:0] stamp;
	} dslog_rec_s;
	// Event offered by the terminal logic
	typedef struct packed {
		logic valid;
		logic [31:0] code;
		logic [15:0] text_index;
	} dslog_event_s;
endpackage : dslog_pkg

// ### rtl/dslog_top.sv
// Purpose: status indicators plus a ring of diagnostic event records
// Assumes: all inputs synchronous to pclk; master reaches the log over APB
// Notes: timestamps come from the distributed clock when it is valid
// How it works
// R1 - Run indicator dark while slave state is INIT.
// R2 - Run indicator flashes in PREOP.
// R3 - Single flash in SAFEOP; outputs held safe.
// R4 - Run indicator steady in OP; mailbox and process data allowed.
// R5 - Run indicator flickers in BOOTSTRAP.
// R6 - Voltage error indicator follows voltage range overflow.
// R7 - One red indicator per current phase follows that phase's overflow.
// R8 - Every warning, error or status event stores a coded record.
// R9 - History lives at object index 0x10F3, readable by the master.
// R10 - History keeps at most 250 records.
// R11 - Record holds code, severity flags, text index, 64-bit timestamp.
// R12 - Stamp is distributed clock time if available, else local time.
// R13 - Stamp is sampled in the cycle of the event.
// R14 - Unread indication tells the master new records exist.
// R15 - Master may confirm the newest unconfirmed record.
// R16 - Subindex 2 shows the subindex of the newest record.
// R17 - Nonzero subindex 5 reports each new record as emergency.
// R18 - Text index top digit is class: 0,1,4,8; 2 reserved.
// R19 - Second digit is area, low two digits the number.
// R20 - When full, the newest record overwrites the oldest.
// R21 - Indicator patterns come from fixed prescaled clock periods.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
module dslog_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminal status
	input wire dslog_pkg::dslog_state_e slave_state,
	input wire logic volt_range_err,
	input wire logic [2:0] phase_range_err,
	input wire dslog_pkg::dslog_event_s diag_event,
	// Time sources
	input wire logic dist_time_valid,
	input wire logic [63:0] distributed_clock_time,
	// Indicators and link status
	output logic run_led,
	output logic volt_err_led,
	output logic [2:0] phase_current_error_leds,
	output logic outputs_safe,
	output logic pd_exchange_en,
	output logic emcy_req
);
	import dslog_pkg::*;

	// History ring; slot k is reported as subindex k plus the first record subindex
	dslog_rec_s mem [MAX_RECORDS];
	// Ring state, read select and emergency control
	logic [7:0] wr_ptr_r, wr_ptr_nxt, count_r, count_nxt, newest_r, newest_nxt, sel_r, sel_nxt;
	logic unread_r, unread_nxt, emcy_en_r, emcy_en_nxt, emcy_r, emcy_nxt;
	logic [63:0] local_time_r, local_time_nxt;
	logic [27:0] flash_cnt_r, flash_cnt_nxt, flick_cnt_r, flick_cnt_nxt;
	logic flash_ph_r, flash_ph_nxt, flick_ph_r, flick_ph_nxt;
	logic [2:0] slot_r, slot_nxt;
	logic run_nxt;
	logic [31:0] rd_nxt, prdata_r;
	logic err_nxt, pslverr_r, pready_r;
	logic acc, wr_acc, rd_acc, ack_wr;
	logic [7:0] ack_sub;
	logic [15:0] sev;
	dslog_rec_s rec_sel, rec_new;
	logic conf_we;
	logic [7:0] conf_slot;
	logic pready_nxt, pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic volt_nxt, safe_nxt, pdx_nxt;
	logic [2:0] phase_nxt;

	assign acc = psel && penable && pready_r;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign ack_wr = wr_acc && (paddr == OFF_ACK_SUB);
	assign ack_sub = pwdata[7:0];
	assign rec_sel = mem[sel_r];
	// Confirm only the newest record, and only while it is still unread [R15]
	assign conf_we = ack_wr && unread_r && count_r != 8'h00 && ack_sub == newest_r;
	assign conf_slot = ack_sub - FIRST_SUB;

	// Severity from the class digit of the text index
	always_comb begin
		case (diag_event.text_index[15:12]) // [R18]
			CLASS_WARN: sev = SEV_WARN;
			CLASS_ERR: sev = SEV_ERR;
			default: sev = SEV_INFO; // Area and number pass through untouched [R19]
		endcase
	end

	// Record assembled in the event cycle, so the stamp is that cycle's time
	always_comb begin
		rec_new.code = diag_event.code; // [R8] [R11]
		rec_new.flags = sev;
		rec_new.text_index = diag_event.text_index;
		// Distributed clock when valid, else local time [R12] [R13]
		rec_new.stamp = dist_time_valid ? distributed_clock_time : local_time_r;
	end

	// Record store; no reset, count and pointers say which slots hold data
	always_ff @(posedge pclk) begin
		if (diag_event.valid) begin
			mem[wr_ptr_r] <= rec_new; // [R8]
		end
		if (conf_we) begin
			// Only the confirmed bit changes; the rest of the record is kept
			mem[conf_slot].flags[FLAG_CONFIRMED_BIT] <= 1'b1; // [R15]
		end
	end

	// Free running local slave time; wraps only after 2^64 cycles
	always_comb begin
		local_time_nxt = local_time_r + 64'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_time_r <= 64'h0;
		end else begin
			local_time_r <= local_time_nxt;
		end
	end

	// Ring pointers, unread flag and emergency request
	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		count_nxt = count_r;
		newest_nxt = newest_r;
		unread_nxt = unread_r;
		emcy_en_nxt = emcy_en_r;
		emcy_nxt = 1'b0;
		sel_nxt = sel_r;
		// Confirm of the newest clears unread; a same-cycle event sets it again below
		if (ack_wr && ack_sub == newest_r) begin
			unread_nxt = 1'b0;
		end
		if (wr_acc && paddr == OFF_EMCY_EN) begin
			emcy_en_nxt = (pwdata != 32'h0); // [R17]
		end
		// Out of range selects fall back to slot zero rather than reading past the ring
		if (wr_acc && paddr == OFF_SEL) begin
			sel_nxt = (pwdata[7:0] < 8'(MAX_RECORDS)) ? pwdata[7:0] : 8'h00;
		end
		if (diag_event.valid) begin
			// Wrap keeps the oldest slot as the next victim [R20]
			wr_ptr_nxt = (wr_ptr_r == 8'(MAX_RECORDS - 1)) ? 8'h00 : wr_ptr_r + 8'h01;
			if (count_r != 8'(MAX_RECORDS)) begin
				count_nxt = count_r + 8'h01; // [R10]
			end
			newest_nxt = wr_ptr_r + FIRST_SUB; // [R16]
			unread_nxt = 1'b1; // Set wins over a same-cycle confirm [R14]
			emcy_nxt = emcy_en_r; // [R17]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r <= 8'h00;
			count_r <= 8'h00;
			newest_r <= 8'h00;
			unread_r <= 1'b0;
			emcy_en_r <= EMCY_EN_RST;
			emcy_r <= 1'b0;
			sel_r <= 8'h00;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			count_r <= count_nxt;
			newest_r <= newest_nxt;
			unread_r <= unread_nxt;
			emcy_en_r <= emcy_en_nxt;
			emcy_r <= emcy_nxt;
			sel_r <= sel_nxt;
		end
	end

	// APB read mux; one wait state so the record array read is registered
	always_comb begin
		rd_nxt = 32'h0;
		err_nxt = 1'b0;
		case (paddr)
			OFF_NEWEST_SUB: rd_nxt = {24'h0, newest_r}; // [R16]
			OFF_ACK_SUB: rd_nxt = 32'h0;
			OFF_UNREAD: rd_nxt = {31'h0, unread_r}; // [R14]
			OFF_EMCY_EN: rd_nxt = {31'h0, emcy_en_r};
			OFF_COUNT: rd_nxt = {24'h0, count_r};
			OFF_SEL: rd_nxt = {24'h0, sel_r};
			OFF_REC_CODE: rd_nxt = rec_sel.code; // [R9]
			OFF_REC_FLAGS: rd_nxt = {rec_sel.text_index, rec_sel.flags};
			OFF_REC_TS_LO: rd_nxt = rec_sel.stamp[31:0];
			OFF_REC_TS_HI: rd_nxt = rec_sel.stamp[63:32];
			OFF_OBJ_INDEX: rd_nxt = {16'h0, HISTORY_INDEX}; // [R9]
			default: err_nxt = 1'b1;
		endcase
	end

	// Answer one edge after the first access edge; data and error stand with it only
	always_comb begin
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0;
		if (psel && penable && !pready_r) begin
			pready_nxt = 1'b1; // [R9]
			pslverr_nxt = err_nxt; // Unmapped address refused
			if (!pwrite) begin
				prdata_nxt = rd_nxt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Indicator and link status next values
	always_comb begin
		volt_nxt = volt_range_err; // [R6]
		// Anything short of OP keeps outputs safe, SAFEOP included [R3]
		safe_nxt = (slave_state != DSLOG_OP);
		pdx_nxt = (slave_state == DSLOG_OP); // [R4]
	end

	// One red indicator per current phase, each following only its own range flag
	for (genvar g = 0; g < 3; g++) begin : g_phase
		assign phase_nxt[g] = phase_range_err[g]; // [R7]
	end

	// Indicator prescalers; flicker runs four times faster than flash
	always_comb begin
		flash_cnt_nxt = flash_cnt_r + 28'h1;
		flash_ph_nxt = flash_ph_r;
		slot_nxt = slot_r;
		flick_cnt_nxt = flick_cnt_r + 28'h1;
		flick_ph_nxt = flick_ph_r;
		if (flash_cnt_r == 28'(FLASH_HALF_CYC - 1)) begin // [R21]
			flash_cnt_nxt = 28'h0;
			flash_ph_nxt = !flash_ph_r;
			slot_nxt = (slot_r == 3'(SINGLE_OFF_SLOTS)) ? 3'h0 : slot_r + 3'h1;
		end
		if (flick_cnt_r == 28'(FLICK_HALF_CYC - 1)) begin // [R21]
			flick_cnt_nxt = 28'h0;
			flick_ph_nxt = !flick_ph_r;
		end
	end

	// Run indicator pattern picked by the slave state; unknown codes show dark
	always_comb begin
		case (slave_state)
			DSLOG_INIT: run_nxt = 1'b0; // [R1]
			DSLOG_PREOP: run_nxt = flash_ph_r; // [R2]
			DSLOG_SAFEOP: run_nxt = (slot_r == 3'h0); // [R3]
			DSLOG_OP: run_nxt = 1'b1; // [R4]
			DSLOG_BOOT: run_nxt = flick_ph_r; // [R5]
			default: run_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_cnt_r <= 28'h0;
			flick_cnt_r <= 28'h0;
			flash_ph_r <= 1'b0;
			flick_ph_r <= 1'b0;
			slot_r <= 3'h0;
			run_led <= 1'b0;
			volt_err_led <= 1'b0;
			phase_current_error_leds <= 3'h0;
			outputs_safe <= 1'b1;
			pd_exchange_en <= 1'b0;
		end else begin
			flash_cnt_r <= flash_cnt_nxt;
			flick_cnt_r <= flick_cnt_nxt;
			flash_ph_r <= flash_ph_nxt;
			flick_ph_r <= flick_ph_nxt;
			slot_r <= slot_nxt;
			run_led <= run_nxt;
			volt_err_led <= volt_nxt;
			phase_current_error_leds <= phase_nxt;
			outputs_safe <= safe_nxt;
			pd_exchange_en <= pdx_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign emcy_req = emcy_r;
endmodule : dslog_top

// ### test/dslog_chk_sva.sv
// Purpose: port checks for dslog_top
// Assumes: one clock, async low reset
// Notes: blink periods too long to watch here
module dslog_chk import dslog_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Terminal
	input wire dslog_state_e slave_state,
	input wire logic volt_range_err,
	input wire logic [2:0] phase_range_err,
	input wire dslog_event_s diag_event,
	input wire logic run_led,
	input wire logic volt_err_led,
	input wire logic [2:0] phase_current_error_leds,
	input wire logic outputs_safe,
	input wire logic pd_exchange_en,
	input wire logic emcy_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_init_dark: assert property ((slave_state == DSLOG_INIT) [*2] |-> !run_led)
		else $error("run led lit in init");
	a_op_lit: assert property ((slave_state == DSLOG_OP) [*2] |-> run_led)
		else $error("run led dark in op");
	a_volt_follow: assert property (1 |=> volt_err_led == $past(volt_range_err))
		else $error("voltage led wrong");
	a_phase_follow: assert property (1 |=> phase_current_error_leds == $past(phase_range_err))
		else $error("phase leds wrong");
	a_safe_hold: assert property (slave_state != DSLOG_OP |=> outputs_safe)
		else $error("outputs not safe");
	a_op_exchange: assert property (slave_state == DSLOG_OP |=> pd_exchange_en && !outputs_safe)
		else $error("process data off in op");
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_emcy_cause: assert property (emcy_req |-> $past(diag_event.valid))
		else $error("emergency without event");
endmodule : dslog_chk

bind dslog_top dslog_chk dslog_chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.slave_state(slave_state), .volt_range_err(volt_range_err),
	.phase_range_err(phase_range_err), .diag_event(diag_event),
	.run_led(run_led), .volt_err_led(volt_err_led),
	.phase_current_error_leds(phase_current_error_leds), .outputs_safe(outputs_safe),
	.pd_exchange_en(pd_exchange_en), .emcy_req(emcy_req)
);

// ### test/dslog_apb_master.sv
// Purpose: fieldbus master reaching the history over APB
// Assumes: call right after a rising edge
// Notes: a stuck slave sets timed_out
module dslog_apb_master (
	// Clock
	input wire logic pclk,
	// APB
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	output logic timed_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata, timed_out} = '0;
	end
	// One access, held until pready is sampled; idle edge after it avoids double drives
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 200);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'h1) timed_out <= 1'h1;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer
endmodule : dslog_apb_master

// ### test/diag_status_leds_and_event_log_test.sv
// Purpose: self-checking bench for dslog_top
// Assumes: one wait state APB, events stamped at their edge
// Notes: blink patterns left to long runs
module diag_status_leds_and_event_log_test import dslog_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timed_out, err, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	dslog_state_e slave_state;
	logic volt_range_err, dist_time_valid, run_led, volt_err_led, outputs_safe, pd_exchange_en;
	logic emcy_req;
	logic [2:0] phase_range_err, phase_current_error_leds;
	dslog_event_s diag_event;
	logic [63:0] distributed_clock_time;
	int fail_count = 0;
	int num_checks = 0;
	dslog_top dslog_top_i (
		.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slave_state(slave_state), .volt_range_err(volt_range_err),
		.phase_range_err(phase_range_err), .diag_event(diag_event),
		.dist_time_valid(dist_time_valid), .distributed_clock_time(distributed_clock_time),
		.run_led(run_led), .volt_err_led(volt_err_led),
		.phase_current_error_leds(phase_current_error_leds), .outputs_safe(outputs_safe),
		.pd_exchange_en(pd_exchange_en), .emcy_req(emcy_req)
	);
	dslog_apb_master dslog_apb_master_i (
		.pclk(pclk),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timed_out(timed_out)
	);
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	task automatic stop_test;
		if (timed_out !== 1'h0) begin
			fail_count++;
			$display("mismatch at %0t: bus access timed out", $time);
		end
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// Any stuck access ends the run at once
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		dslog_apb_master_i.xfer(w, a, d, rd, err);
		if (timed_out !== 1'h0) stop_test;
	endtask : acc
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		acc(1'h0, a, 32'h0);
		chk(rd, exp, what);
	endtask : rd_chk
	// Back-to-back events, then emergency seen one edge later
	task automatic post(input int n, input logic [31:0] c, input logic [15:0] t, output logic em);
		for (int i = 0; i < n; i++) begin
			diag_event <= '{1'h1, c + i, t};
			@(posedge pclk);
		end
		diag_event.valid <= 1'h0;
		@(posedge pclk);
		em = emcy_req;
	endtask : post
	initial begin
		{pclk, presetn, volt_range_err, phase_range_err, diag_event} = '0;
		slave_state = DSLOG_INIT;
		dist_time_valid = 1'h1;
		distributed_clock_time = 64'h0123_4567_89ab_cdef;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk(run_led, 1'h0, "run led init");
		chk(outputs_safe, 1'h1, "safe");
		rd_chk(OFF_OBJ_INDEX, {16'h0, HISTORY_INDEX}, "index");
		rd_chk(OFF_EMCY_EN, 32'h1, "emcy rst");
		rd_chk(OFF_NEWEST_SUB, 32'h0, "empty");
		rd_chk(12'h100, 32'h0, "unmapped");
		chk(err, 1'h1, "slverr");
		post(1, 32'hdead_0001, 16'h4413, e);
		chk(e, 1'h1, "emcy");
		rd_chk(OFF_NEWEST_SUB, 32'h6, "newest");
		rd_chk(OFF_UNREAD, 32'h1, "unread");
		rd_chk(OFF_COUNT, 32'h1, "count");
		acc(1'h1, OFF_SEL, 32'h0);
		rd_chk(OFF_REC_CODE, 32'hdead_0001, "code");
		rd_chk(OFF_REC_FLAGS, {16'h4413, SEV_WARN}, "warn");
		rd_chk(OFF_REC_TS_LO, 32'h89ab_cdef, "ts lo");
		rd_chk(OFF_REC_TS_HI, 32'h0123_4567, "ts hi");
		acc(1'h1, OFF_ACK_SUB, 32'h6);
		rd_chk(OFF_UNREAD, 32'h0, "unread clr");
		rd_chk(OFF_REC_FLAGS, {16'h4413, SEV_WARN | (16'h1 << FLAG_CONFIRMED_BIT)}, "ack");
		acc(1'h1, OFF_EMCY_EN, 32'h0);
		dist_time_valid <= 1'h0;
		post(1, 32'hbeef_0002, 16'h8201, e);
		chk(e, 1'h0, "emcy off");
		acc(1'h1, OFF_SEL, 32'h1);
		rd_chk(OFF_REC_FLAGS, {16'h8201, SEV_ERR}, "err");
		rd_chk(OFF_REC_TS_HI, 32'h0, "local ts");
		post(250, 32'h0, 16'h1012, e);
		chk(e, 1'h0, "emcy still off");
		rd_chk(OFF_COUNT, 32'd250, "full");
		rd_chk(OFF_NEWEST_SUB, 32'h7, "wrap");
		acc(1'h1, OFF_ACK_SUB, 32'h6);
		rd_chk(OFF_UNREAD, 32'h1, "stale ack");
		rd_chk(OFF_REC_FLAGS, {16'h1012, SEV_INFO}, "info");
		acc(1'h1, OFF_SEL, 32'h0);
		rd_chk(OFF_REC_CODE, 32'hf8, "overwrite");
		volt_range_err <= 1'h1;
		phase_range_err <= 3'h5;
		slave_state <= DSLOG_OP;
		repeat (3) @(posedge pclk);
		chk(volt_err_led, 1'h1, "volt");
		chk(phase_current_error_leds, 3'h5, "phase");
		chk(run_led, 1'h1, "run op");
		chk(pd_exchange_en, 1'h1, "pd");
		chk(outputs_safe, 1'h0, "unsafe");
		volt_range_err <= 1'h0;
		phase_range_err <= 3'h2;
		slave_state <= DSLOG_SAFEOP;
		repeat (3) @(posedge pclk);
		chk(volt_err_led, 1'h0, "volt off");
		chk(phase_current_error_leds, 3'h2, "phase 2");
		chk(outputs_safe, 1'h1, "safeop");
		stop_test;
	end
endmodule : diag_status_leds_and_event_log_test
